/* hdl/fault_ctrl_pkg.sv */
/*
 * Constants for the transceiver fault and supervision logic: timer lengths,
 * reset levels of the outputs.
 * Assumes a 50 MHz system clock; the timer counts are derived from that rate.
 */
package fault_ctrl_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_HZ = 50_000_000;
    localparam int DTO_US = 1200;                      // Least dominant timeout, us
    localparam int DTO_CYCLES = DTO_US * (CLK_HZ / 1_000_000);
    localparam int SWE_US = 1000;                      // Standby error timeout, plain default
    localparam int SWE_CYCLES = SWE_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 24;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic TXD_RST = 1'b1;                   // Recessive
    localparam logic SLP_RST = 1'b0;                   // Sleep request asserted
    localparam logic STATUS_RST = 1'b0;
    localparam logic RXD_RST = 1'b1;
    // Synchroniser idle: txd high, driven, sleep low, driven, bus recessive, cool, no supply fault
    localparam logic [7:0] SYNC_RST = 8'hda;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_STANDBY,
        MODE_NORMAL,
        MODE_FAILSAFE
    } mode_t;

endpackage

/* hdl/can_fault_control.sv */
/*
 * Fault handling and mode supervision of a CAN FD transceiver: dominant
 * timeout, thermal and supply fail-safe, floating-pin defaults, standby
 * error timer.
 * Assumes pins arrive asynchronous and analog detectors deliver digital flags.
 * Every pin passes two flip-flops, so pin effects reach the internal state
 * three edges late and most outputs four edges late; bus_tx_dominant and rxd_out follow txd and bus three edges late.
 * The two timers are plain cycle counts of the system clock; the caller
 * scales them to the wanted times through the parameters.
 * Wake patterns, the inhibit output and short-circuit limiting are not
 * modelled: sleep is left only when the sleep control pin goes high or a fault forces fail-safe.
 * Driven flags stand in for the pin pull-up and pull-down: a low flag
 * means the pin floats and its safe default is used instead.
 */
// Behaviour
// - Dominant timeout supervision runs only while the bus driver is active.
// - Each falling edge of transmit data starts the timeout measurement.
// - No rising edge before timeout: disable driver, bus goes recessive.
// - A later rising transmit edge clears the timeout fault and re-enables sending.
// - During a timeout fault the receiver keeps working and receive follows bus.
// - Status output held low while a dominant timeout fault is active.
// - Over-temperature trip enters fail-safe, disabling transmitter and receiver.
// - Thermal fault clears only below release threshold; re-enters on rising again.
// - Undervoltage on any monitored supply enters fail-safe mode.
// - Overvoltage on any monitored supply enters fail-safe mode.
// - Undriven transmit input reads high, recessive.
// - Undriven sleep control input reads low, forcing sleep.
// - Standby error timer starts on entering standby, counts only in standby.
// - Leaving standby before expiry stops the standby error timer.
// - Timer expiry in standby drives receive output low as interrupt.
// - After expiry and interrupt, move from standby into sleep.
// - Status high only in normal mode without timeout fault, else low.
// - Status forced low whenever thermal shutdown is present.
`timescale 1ns/1ps

module can_fault_control
    import fault_ctrl_pkg::*;
#(
    parameter int DTO_COUNT = DTO_CYCLES,
    parameter int SWE_COUNT = SWE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic txd_in,
    input wire logic txd_driven,
    input wire logic sleep_request_low,
    input wire logic sleep_driven,
    input wire logic bus_rx_in,
    input wire logic thermal_trip_threshold,
    input wire logic thermal_release_threshold,
    input wire logic supply_under,
    input wire logic supply_over,
    output logic driver_en,
    output logic bus_tx_dominant,
    output logic receiver_en,
    output logic rxd_out,
    output logic transceiver_status_out,
    output logic dominant_timeout_fault,
    output logic thermal_shutdown_fault,
    output fault_ctrl_pkg::mode_t mode_out
);
    import fault_ctrl_pkg::*;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] raw;

    assign raw = {txd_in, txd_driven, sleep_request_low, sleep_driven, bus_rx_in,
                  thermal_trip_threshold, thermal_release_threshold, supply_under | supply_over};

    // First stage catches the pins; metastability settles here
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            s1_q <= SYNC_RST;
        else
            s1_q <= raw;
    end

    // Second stage; only this one is read by logic
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            s2_q <= SYNC_RST;
        else
            s2_q <= s1_q;
    end

    logic txd_raw, txd_drv, slp_raw, slp_drv, bus_rx, t_hot, t_cool, supply_bad;
    assign {txd_raw, txd_drv, slp_raw, slp_drv, bus_rx, t_hot, t_cool, supply_bad} = s2_q;

    // ==========================================================
    // Floating-pin defaults
    // ==========================================================
    logic txd_s;
    logic slp_s;
    assign txd_s = txd_drv ? txd_raw : TXD_RST;
    assign slp_s = slp_drv ? slp_raw : SLP_RST;

    // ==========================================================
    // Thermal fault with hysteresis
    // ==========================================================
    logic tsd_q;
    logic tsd_d;
    // Set wins: trip held while between thresholds
    assign tsd_d = t_hot ? 1'b1 : (t_cool ? 1'b0 : tsd_q);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            tsd_q <= 1'b0;
        else
            tsd_q <= tsd_d;
    end

    // ==========================================================
    // Mode control
    // ==========================================================
    mode_t mode_q;
    mode_t mode_d;
    logic swe_expire;
    logic fail_any;
    assign fail_any = tsd_q | supply_bad;

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            // Exit only once every fault flag is gone
            MODE_FAILSAFE: begin
                if (!fail_any)
                    mode_d = slp_s ? MODE_NORMAL : MODE_STANDBY;
            end
            // Low sleep control parks the transceiver
            MODE_NORMAL: begin
                if (!slp_s)
                    mode_d = MODE_STANDBY;
            end
            // Host wake beats timer expiry in the same cycle
            MODE_STANDBY: begin
                if (slp_s)
                    mode_d = MODE_NORMAL;
                else if (swe_expire)
                    mode_d = MODE_SLEEP;
            end
            // No wake patterns here, so only the pin wakes us
            MODE_SLEEP: begin
                if (slp_s)
                    mode_d = MODE_NORMAL;
            end
            default: mode_d = MODE_FAILSAFE;
        endcase
        if (fail_any)
            mode_d = MODE_FAILSAFE;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            mode_q <= MODE_STANDBY;
        else
            mode_q <= mode_d;
    end

    // ==========================================================
    // Standby error timer
    // ==========================================================
    logic [CNT_W-1:0] swe_q;
    logic swe_int_q;
    // Counts only in standby; any other mode clears it
    assign swe_expire = (mode_q == MODE_STANDBY) && (swe_q == CNT_W'(SWE_COUNT - 1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            swe_q <= '0;
        else if (mode_q != MODE_STANDBY || mode_d != MODE_STANDBY)
            swe_q <= '0;
        else
            swe_q <= swe_q + CNT_W'(1);
    end

    // Interrupt latches low until sleep is left for normal or fail-safe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            swe_int_q <= 1'b0;
        else if (swe_expire)
            swe_int_q <= 1'b1;
        else if (mode_q == MODE_NORMAL || mode_q == MODE_FAILSAFE)
            swe_int_q <= 1'b0;
    end

    // ==========================================================
    // Dominant timeout
    // ==========================================================
    logic txd_prev_q;
    logic [CNT_W-1:0] dto_q;
    logic dto_run_q;
    logic dto_q_f;
    logic drv_active;
    logic fall;
    logic rise;
    logic dto_hit;

    // Terminal count; counter, fault flag and driver enable all watch it
    function automatic logic dto_run_q_hit(input logic run, input logic [CNT_W-1:0] c);
        dto_run_q_hit = run && (c == CNT_W'(DTO_COUNT - 1));
    endfunction

    // Edges come after the pin defaults, so a floating pin never starts a run
    assign drv_active = (mode_q == MODE_NORMAL);
    assign fall = txd_prev_q & ~txd_s;
    assign rise = ~txd_prev_q & txd_s;
    assign dto_hit = dto_run_q_hit(dto_run_q, dto_q);

    // Previous level resets recessive, so no false edge follows reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            txd_prev_q <= TXD_RST;
        else
            txd_prev_q <= txd_s;
    end

    // Run flag: armed by a fall, dropped by a rise or by leaving normal
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            dto_run_q <= 1'b0;
        else if (!drv_active || rise)
            dto_run_q <= 1'b0;
        else if (fall)
            dto_run_q <= 1'b1;
    end

    // Counter parks at the terminal count so the fault cannot wrap away
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            dto_q <= '0;
        else if (!drv_active || rise || fall)
            dto_q <= '0;
        else if (dto_run_q && !dto_hit)
            dto_q <= dto_q + CNT_W'(1);
    end

    // Fault stays until a rising edge or leaving normal; a new fall cannot coexist with it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            dto_q_f <= 1'b0;
        else if (rise || !drv_active)
            dto_q_f <= 1'b0;
        else if (dto_hit)
            dto_q_f <= 1'b1;
    end

    // ==========================================================
    // Registered outputs
    // ==========================================================
    logic drv_en_d;
    logic rx_en_d;
    logic rxd_d;
    logic status_d;

    // Driver drops on the terminal count itself, on the same edge the flag sets, one edge ahead of dominant_timeout_fault
    assign drv_en_d = drv_active && !dto_q_f && !dto_hit;
    assign rx_en_d = (mode_q == MODE_NORMAL);
    assign rxd_d = swe_int_q ? 1'b0 : (rx_en_d ? bus_rx : RXD_RST);
    assign status_d = drv_active && !dto_q_f && !tsd_q;

    // Bus driver enable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            driver_en <= 1'b0;
        else
            driver_en <= drv_en_d;
    end

    // Dominant only while enabled, so a timeout leaves the bus recessive
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            bus_tx_dominant <= 1'b0;
        else
            bus_tx_dominant <= drv_en_d & ~txd_s;
    end

    // Receiver enable
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            receiver_en <= 1'b0;
        else
            receiver_en <= rx_en_d;
    end

    // Receive data; the standby interrupt overrides the bus level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rxd_out <= RXD_RST;
        else
            rxd_out <= rxd_d;
    end

    // Status pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            transceiver_status_out <= STATUS_RST;
        else
            transceiver_status_out <= status_d;
    end

    // Timeout fault, one edge behind the internal flag
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            dominant_timeout_fault <= 1'b0;
        else
            dominant_timeout_fault <= dto_q_f;
    end

    // Thermal fault, one edge behind the internal flag
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            thermal_shutdown_fault <= 1'b0;
        else
            thermal_shutdown_fault <= tsd_q;
    end

    // Mode, one edge behind the state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            mode_out <= MODE_STANDBY;
        else
            mode_out <= mode_q;
    end

endmodule

/* tb/fault_checker.sv */
/* Assertion checker for can_fault_control, watching its ports only.
   Assumes the bind below hands on the timer counts of each instance. */
`timescale 1ns/1ps
module fault_checker
    import fault_ctrl_pkg::*;
#(
    parameter int DTO_COUNT = 20,
    parameter int SWE_COUNT = 30
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic txd_in,
    input wire logic bus_rx_in,
    input wire logic thermal_trip_threshold,
    input wire logic thermal_release_threshold,
    input wire logic driver_en,
    input wire logic receiver_en,
    input wire logic rxd_out,
    input wire logic transceiver_status_out,
    input wire logic dominant_timeout_fault,
    input wire logic thermal_shutdown_fault,
    input wire fault_ctrl_pkg::mode_t mode_out
);
    // ====================
    // Run-length counters
    // ====================
    int low_cnt_q;
    int stby_cnt_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Pin-level run lengths, so sync lag only ever lengthens them
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_q <= 0;
            stby_cnt_q <= 0;
        end else begin
            low_cnt_q <= txd_in ? 0 : low_cnt_q + 1;
            stby_cnt_q <= (mode_out == MODE_STANDBY) ? stby_cnt_q + 1 : 0;
        end
    end
    // Steps of a quiet bus and of a timer expiry
    sequence s_quiet; (mode_out == MODE_NORMAL && $stable(bus_rx_in)) [*5]; endsequence
    sequence s_expire; $past(mode_out) == MODE_STANDBY && mode_out == MODE_SLEEP; endsequence
    property p_dto_len; $rose(dominant_timeout_fault) |-> low_cnt_q >= DTO_COUNT; endproperty
    a_dto_len: assert property (p_dto_len) else $error("timeout raised early");
    property p_dto_off; dominant_timeout_fault [*2] |-> !driver_en && !transceiver_status_out; endproperty
    a_dto_off: assert property (p_dto_off) else $error("driver on during timeout");
    property p_rx; s_quiet |-> rxd_out == bus_rx_in; endproperty
    a_rx: assert property (p_rx) else $error("receive not following bus");
    property p_off;
        (mode_out != MODE_NORMAL) [*2] |-> !driver_en && !receiver_en && !transceiver_status_out;
    endproperty
    a_off: assert property (p_off) else $error("active outside normal");
    property p_tsd_set; thermal_trip_threshold [*5] |-> thermal_shutdown_fault; endproperty
    a_tsd_set: assert property (p_tsd_set) else $error("thermal trip missed");
    property p_tsd_fs;
        thermal_shutdown_fault [*3] |-> mode_out == MODE_FAILSAFE && !transceiver_status_out;
    endproperty
    a_tsd_fs: assert property (p_tsd_fs) else $error("thermal not fail-safe");
    property p_tsd_hold;
        (!thermal_release_threshold [*4]) ##0 thermal_shutdown_fault |=> thermal_shutdown_fault;
    endproperty
    a_tsd_hold: assert property (p_tsd_hold) else $error("thermal cleared early");
    property p_swe_len; stby_cnt_q <= SWE_COUNT + 3; endproperty
    a_swe_len: assert property (p_swe_len) else $error("standby overstayed");
    property p_swe_irq; s_expire |=> !rxd_out; endproperty
    a_swe_irq: assert property (p_swe_irq) else $error("no interrupt on expiry");
endmodule

bind can_fault_control fault_checker #(.DTO_COUNT(DTO_COUNT), .SWE_COUNT(SWE_COUNT)) chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .txd_in(txd_in), .bus_rx_in(bus_rx_in),
    .thermal_trip_threshold(thermal_trip_threshold),
    .thermal_release_threshold(thermal_release_threshold),
    .driver_en(driver_en), .receiver_en(receiver_en), .rxd_out(rxd_out),
    .transceiver_status_out(transceiver_status_out),
    .dominant_timeout_fault(dominant_timeout_fault),
    .thermal_shutdown_fault(thermal_shutdown_fault), .mode_out(mode_out));

/* tb/host_model.sv */
/* Host controller model driving transmit data and the sleep control pin.
   Assumes one bus bit per clock; the bench calls its tasks. */
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys,
    output logic txd_in,
    output logic sleep_request_low
);
    // ====================
    // Pin drivers
    // ====================
    initial begin
        txd_in = 1'b1;
        sleep_request_low = 1'b0;
    end
    task automatic set_txd(input logic v);
        @(posedge clk_sys);
        txd_in <= v;
    endtask
    task automatic set_mode(input logic v);
        @(posedge clk_sys);
        sleep_request_low <= v;
    endtask
    // Random bits, dominant runs capped at eleven as the protocol allows
    task automatic send_frame(input int n);
        int run;
        logic b;
        run = 0;
        repeat (n) begin
            b = (run < 11) ? 1'($urandom_range(1, 0)) : 1'b1;
            run = b ? 0 : run + 1;
            @(posedge clk_sys);
            txd_in <= b;
        end
        set_txd(1'b1);
    endtask
endmodule

/* tb/tb_top.sv */
/* Self-checking bench for can_fault_control with the host model on its pins.
   Assumes shortened timer counts; the checker is attached by bind. */
`timescale 1ns/1ps
module tb_top;
    import fault_ctrl_pkg::*;
    localparam int DTO = 20;
    localparam int SLEEP_WAKE_ERROR_TIMER = 30;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic txd_driven = 1'b1;
    logic sleep_driven = 1'b1;
    logic bus_rx_in = 1'b1;
    logic trip = 1'b0;
    logic rel = 1'b0;
    logic uv = 1'b0;
    logic ov = 1'b0;
    logic txd_in, sleep_request_low, driver_en, bus_tx_dominant, receiver_en, rxd_out;
    logic status, dto_fault, tsd_fault;
    mode_t mode_out;
    int n_fail = 0;
    int num_checks = 0;
    always #10 clk_sys = ~clk_sys;
    // Bus echoes our own transmit, with random dominant noise
    always @(posedge clk_sys) bus_rx_in <= txd_in & ($urandom_range(3, 0) != 0);
    host_model host (.clk_sys(clk_sys), .txd_in(txd_in), .sleep_request_low(sleep_request_low));
    can_fault_control #(.DTO_COUNT(DTO), .SWE_COUNT(SLEEP_WAKE_ERROR_TIMER)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .txd_in(txd_in), .txd_driven(txd_driven),
        .sleep_request_low(sleep_request_low), .sleep_driven(sleep_driven),
        .bus_rx_in(bus_rx_in), .thermal_trip_threshold(trip), .thermal_release_threshold(rel),
        .supply_under(uv), .supply_over(ov), .driver_en(driver_en),
        .bus_tx_dominant(bus_tx_dominant), .receiver_en(receiver_en), .rxd_out(rxd_out),
        .transceiver_status_out(status), .dominant_timeout_fault(dto_fault),
        .thermal_shutdown_fault(tsd_fault), .mode_out(mode_out));
    // ====================
    // Check helpers
    // ====================
    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wait_mode(input mode_t m, input int lim, output int n);
        n = 0;
        while (mode_out !== m && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        chk(5'(n < lim), 5'h01);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog at 10,000 cycles, far beyond the few hundred cycles the run needs
    initial begin
        #200_000;
        n_fail++;
        end_of_test();
    end
    // Main sequence
    initial begin
        int n;
        void'($urandom(44136));
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_mode(MODE_SLEEP, 3 * SLEEP_WAKE_ERROR_TIMER, n);
        chk(5'(n >= SLEEP_WAKE_ERROR_TIMER - 2 && n <= SLEEP_WAKE_ERROR_TIMER + 6), 5'h01);
        cyc(2);
        chk(5'(rxd_out), 5'h00);
        host.set_mode(1'b1);
        wait_mode(MODE_NORMAL, 10, n);
        cyc(2);
        chk({2'h0, status, driver_en, receiver_en}, 5'h07);
        repeat (4) host.send_frame(24);
        chk(5'(dto_fault), 5'h00);
        host.set_txd(1'b0);
        cyc(DTO - 2);
        chk(5'(dto_fault), 5'h00);
        cyc(8);
        chk({dto_fault, driver_en, bus_tx_dominant, status, receiver_en}, 5'h11);
        host.set_txd(1'b1);
        cyc(6);
        chk({3'h0, dto_fault, driver_en}, 5'h01);
        // Floating transmit pin must read recessive
        @(posedge clk_sys);
        txd_driven <= 1'b0;
        host.set_txd(1'b0);
        cyc(DTO + 6);
        chk(5'(dto_fault), 5'h00);
        host.set_txd(1'b1);
        txd_driven <= 1'b1;
        sleep_driven <= 1'b0;
        host.set_txd(1'b0);
        cyc(DTO);
        chk({3'h0, dto_fault, mode_out == MODE_STANDBY}, 5'h01);
        host.set_txd(1'b1);
        txd_driven <= 1'b1;
        sleep_driven <= 1'b1;
        wait_mode(MODE_NORMAL, 10, n);
        // Two short standby stays back to back: the timer restarts each time
        repeat (2) begin
            host.set_mode(1'b0);
            cyc(SLEEP_WAKE_ERROR_TIMER - 8);
            chk(5'(mode_out == MODE_STANDBY), 5'h01);
            host.set_mode(1'b1);
            wait_mode(MODE_NORMAL, 10, n);
        end
        @(posedge clk_sys);
        trip <= 1'b1;
        cyc(6);
        chk({tsd_fault, mode_out == MODE_FAILSAFE, status, driver_en, receiver_en}, 5'h18);
        @(posedge clk_sys);
        trip <= 1'b0;
        cyc(8);
        chk(5'(tsd_fault), 5'h01);
        @(posedge clk_sys);
        rel <= 1'b1;
        wait_mode(MODE_NORMAL, 10, n);
        chk(5'(tsd_fault), 5'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            rel <= trip;
            {ov, uv} <= 2'(i + 1);
            cyc(5);
            chk(5'(mode_out == MODE_FAILSAFE), 5'h01);
            @(posedge clk_sys);
            {ov, uv} <= {ov, uv} ^ 2'(i + 1);
            wait_mode(MODE_NORMAL, 10, n);
        end
        end_of_test();
    end
endmodule
